// [bench/flash_chip_model.sv]
// Purpose: Behavioural byte-wide flash chip facing the sequencer
// Assumes: Strobes sampled on mclk; commands decoded from low address bits
// Notes:   Busy lasts a few reads so the toggle poll step really loops
module flash_chip_model (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [23:0] flash_addr,
  input  wire logic [7:0]  flash_dout,
  input  wire logic        flash_we_n,
  input  wire logic        flash_oe_n,
  input  wire logic [15:0] id_val,
  output logic      [7:0]  flash_din
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [logic [23:0]];
  logic [7:0] last_wr;
  logic [7:0] rd_val;
  logic       we_q;
  logic       oe_q;
  logic       id_mode;
  logic       prog;
  logic       arm;
  logic       tog;
  int         step;
  int         busy_cnt;
  // Released bus shows the inverse, never a stale copy
  assign flash_din = flash_oe_n ? ~rd_val : rd_val;
  task automatic take_write(input logic [23:0] a, input logic [7:0] d);
    if (prog)
    begin
      mem[a] = d;
      last_wr = d;
      busy_cnt = 3;
    end
    else if (step == 2 && a[14:0] == 15'h5555)
    begin
      step = 0;
      busy_cnt = 2;
      if (d == 8'ha0)
        prog = 1'b1;
      if (d == 8'h90 || d == 8'hf0)
        id_mode = (d == 8'h90);
      if (d == 8'h80)
        arm = 1'b1;
      if (d == 8'h10 && arm)
      begin
        mem.delete();
        last_wr = 8'hff;
        busy_cnt = 6;
        arm = 1'b0;
      end
    end
    else
      step = (a[14:0] == 15'h5555 && d == 8'haa) ? 1 :
             (step == 1 && a[14:0] == 15'h2aaa && d == 8'h55) ? 2 : 0;
  endtask
  always @(posedge mclk)
  begin
    we_q <= flash_we_n;
    oe_q <= flash_oe_n;
    if (!rst_n)
    begin
      {id_mode, prog, arm, tog} = 4'h0;
      step = 0;
      busy_cnt = 0;
      last_wr = 8'hff;
      rd_val = 8'h00;
    end
    else if (we_q && !flash_we_n)
      take_write(flash_addr, flash_dout);
    else if (oe_q && !flash_oe_n)
    begin
      tog = ~tog;
      prog = 1'b0;
      if (busy_cnt > 0)
      begin
        rd_val = ~last_wr;
        rd_val[6] = tog;
        busy_cnt--;
      end
      else if (id_mode && flash_addr[16:1] == 16'h0000)
        rd_val = flash_addr[0] ? id_val[7:0] : id_val[15:8];
      else if (id_mode)
        rd_val = flash_addr[7:0];
      else
        rd_val = mem.exists(flash_addr) ? mem[flash_addr] : 8'hff;
    end
  end
endmodule

// [bench/flash_seq_chk.sv]
// Purpose: Port-level checks for the flash command sequencer
// Assumes: Bound to flash_sequencer, reset synchronous and active low
// Notes:   Settle gap is counted from the last low cycle of the write strobe
module flash_seq_chk #(
  parameter int settle_ck = 5
) (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        req,
  input wire logic [2:0]  req_op,
  input wire logic        busy,
  input wire logic        done,
  input wire logic        refused,
  input wire logic [23:0] flash_addr,
  input wire logic [7:0]  flash_dout,
  input wire logic        flash_doe,
  input wire logic        flash_we_n,
  input wire logic        flash_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int gap;
  // Saturates so long idle spells cannot wrap
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      gap <= 1000;
    else if (!flash_we_n)
      gap <= 0;
    else if (gap < 1000)
      gap <= gap + 1;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_done_single: assert property (done |=> !done)
    else $error("done pulse longer than one cycle");
  chk_done_busy: assert property ($rose(done) |-> $past(busy))
    else $error("done without preceding busy");
  chk_req_busy: assert property (req && !busy && req_op inside {[3'h1:3'h5]} |=> busy)
    else $error("accepted request did not raise busy");
  chk_strobe_apart: assert property (flash_we_n || flash_oe_n)
    else $error("write and read strobes low together");
  chk_read_nodrive: assert property (!flash_oe_n |-> !flash_doe)
    else $error("data driven during a read");
  chk_write_width: assert property ($fell(flash_we_n) |-> !flash_we_n [*3] ##1 flash_we_n)
    else $error("write strobe not three cycles");
  chk_read_width: assert property ($fell(flash_oe_n) |-> !flash_oe_n [*3] ##1 flash_oe_n)
    else $error("read strobe not three cycles");
  chk_write_hold: assert property (!flash_we_n && !$past(flash_we_n) |->
    $stable(flash_addr) && $stable(flash_dout) && flash_doe)
    else $error("write address or data moved under strobe");
  chk_settle_gap: assert property ($fell(flash_oe_n) |-> gap >= settle_ck - 1)
    else $error("poll read before settle delay");
  cov_refused: cover property (refused);
  cov_write: cover property ($fell(flash_we_n));
  cov_done: cover property (done && !busy);
endmodule

bind flash_sequencer flash_seq_chk #(.settle_ck(settle_ck)) flash_seq_chk_i (
  .mclk(mclk), .rst_n(rst_n), .req(req), .req_op(req_op), .busy(busy), .done(done),
  .refused(refused), .flash_addr(flash_addr), .flash_dout(flash_dout),
  .flash_doe(flash_doe), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n)
);

// [bench/parallel_flash_command_sequencer_bench.sv]
// Purpose: Self-checking bench for the flash command sequencer
// Assumes: Short settle parameter; id table set here, not taken from the design
// Notes:   Expected flash writes and done records are queued by the driver
module parallel_flash_command_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int          settle    = 5;
  localparam logic [15:0] ids [4]   = '{16'h0102, 16'h0304, 16'h0506, 16'h0708};
  localparam logic [1:0]  pgs [4]   = '{2'h0, 2'h1, 2'h2, 2'h1};
  logic        mclk, rst_n, req, wr_valid, wr_ready, busy, done, refused;
  logic        id_known, differ, flash_doe, flash_we_n, flash_oe_n, we_q;
  logic        cur_known, cur_differ;
  logic [2:0]  req_op;
  logic [23:0] req_base, req_addr, req_other, flash_addr;
  logic [7:0]  wr_data, flash_dout, flash_din, b8;
  logic [15:0] id_pair, id_val, cur_pair;
  logic [31:0] wq [$];
  logic [17:0] dq [$];
  logic [7:0]  fq [$];
  int          err_count, samples_checked, cycles;
  int          seed = 32'h93b5;

  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  flash_sequencer #(.depth(32), .id_count(4), .id_table(ids), .id_pages(pgs),
    .settle_ck(settle)) flash_sequencer_i (
    .mclk(mclk), .rst_n(rst_n), .req(req), .req_op(req_op), .req_base(req_base),
    .req_addr(req_addr), .req_other(req_other), .wr_data(wr_data), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .busy(busy), .done(done), .refused(refused), .id_pair(id_pair),
    .id_known(id_known), .differ(differ), .flash_addr(flash_addr), .flash_dout(flash_dout),
    .flash_doe(flash_doe), .flash_din(flash_din), .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n));
  flash_chip_model flash_chip_model_i (
    .mclk(mclk), .rst_n(rst_n), .flash_addr(flash_addr), .flash_dout(flash_dout),
    .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n), .id_val(id_val),
    .flash_din(flash_din));

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_wr(input logic [31:0] got, input logic [31:0] exp);
    cmp(got, exp);
  endtask
  task automatic cmp_rec(input logic [17:0] got, input logic [17:0] exp);
    cmp(32'(got), 32'(exp));
  endtask
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    cmp(got, exp);
  endtask
  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchers: flash writes, done records, FIFO pops, hang limit
  always @(posedge mclk)
  begin
    we_q <= flash_we_n;
    if (rst_n && we_q && !flash_we_n)
      cmp_wr({flash_addr, flash_dout}, wq.size() ? wq.pop_front() : 32'hx);
    if (rst_n && done)
      cmp_rec({id_known, id_pair, differ}, dq.size() ? dq.pop_front() : 18'hx);
    if (wr_valid && wr_ready)
      void'(fq.pop_front());
    cycles++;
    if (cycles == 90000)
    begin
      err_count++;
      summarize();
    end
  end
  always @(negedge mclk)
  begin
    wr_valid <= fq.size() > 0;
    wr_data  <= fq.size() ? fq[0] : 8'h00;
  end

  task automatic cmd(input logic [23:0] b, input logic [7:0] c);
    wq.push_back({b + 24'h005555, 8'haa});
    wq.push_back({b + 24'h002aaa, 8'h55});
    wq.push_back({b + 24'h005555, c});
  endtask
  task automatic pulse_req(input logic [2:0] op, input logic [23:0] b, input logic [23:0] o);
    @(negedge mclk);
    req       = 1'b1;
    req_op    = op;
    req_base  = b;
    req_other = o;
    @(negedge mclk);
    req = 1'b0;
  endtask
  task automatic go(input logic [2:0] op, input logic [23:0] b, input logic [23:0] o);
    dq.push_back({cur_known, cur_pair, cur_differ});
    pulse_req(op, b, o);
    for (int i = 0; i < 40000 && busy !== 1'b0; i++)
      @(negedge mclk);
    repeat (2) @(negedge mclk);
    $display("test op %0d ended at %0t", op, $time);
  endtask
  task automatic id_check(input logic [23:0] b);
    cmd(b, 8'h90);
    go(flash_seq_pkg::op_id_enter, b, 24'h0);
    cur_pair  = id_val;
    cur_known = 1'b0;
    foreach (ids[k])
      if (ids[k] == id_val)
        cur_known = 1'b1;
    go(flash_seq_pkg::op_read_id, b, 24'h0);
    cmd(b, 8'hf0);
    go(flash_seq_pkg::op_id_leave, b, 24'h0);
  endtask
  task automatic program_page(input logic [23:0] a, input int len);
    cmd(24'h0, 8'ha0);
    for (int n = 0; n < len; n++)
    begin
      b8 = 8'($random(seed));
      fq.push_back(b8);
      wq.push_back({a + 24'(n), b8});
    end
    req_addr = a;
  endtask

  initial
  begin
    {req, rst_n, cur_known, cur_differ} = 4'h0;
    {req_op, req_base, req_addr, req_other} = '0;
    {err_count, samples_checked, cycles} = '0;
    id_val   = 16'h1234;
    cur_pair = 16'h0000;
    repeat (16) @(negedge mclk);
    cmp_val({busy, done, flash_we_n, flash_oe_n, flash_doe}, 32'h6);
    rst_n = 1'b1;
    id_check(24'h040000);
    pulse_req(flash_seq_pkg::op_program, 24'h0, 24'h0);
    for (int i = 0; i < 4 && refused !== 1'b1; i++)
      @(negedge mclk);
    cmp_val(refused, 1'b1);
    $display("test refused ended at %0t", $time);
    id_val = 16'h0304;
    id_check(24'h0);
    program_page(24'h000100, 128);
    repeat (40) @(negedge mclk);
    cmp_val({wr_ready, 31'(fq.size())}, 32'd96); // Full FIFO holds 32 bytes
    go(flash_seq_pkg::op_program, 24'h0, 24'h0);
    cmp_val({wr_ready, 31'(fq.size())}, 32'h80000000); // Drained empty
    cur_differ = 1'b1;
    go(flash_seq_pkg::op_compare, 24'h0, 24'h020000);
    cmd(24'h0, 8'h80);
    cmd(24'h0, 8'h10);
    go(flash_seq_pkg::op_erase, 24'h0, 24'h0);
    cur_differ = 1'b0;
    go(flash_seq_pkg::op_compare, 24'h0, 24'h400000);
    id_val = 16'h0102;
    id_check(24'h0);
    program_page(24'h000005, 1);
    go(flash_seq_pkg::op_program, 24'h0, 24'h0);
    cmp_val(wq.size() + dq.size(), 32'd0);
    summarize();
  end
endmodule

// [src/flash_fifo.sv]
// Purpose: Page data buffer in front of the flash write path
// Assumes: Depth is a power of two
// Notes:   Full and empty come from an occupancy count, no bubble
module flash_fifo #(
  parameter int width = 8,
  parameter int depth = 32
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  flash_stream_if.sink   wr,
  flash_stream_if.source rd
);
  localparam int aw = $clog2(depth);
  logic [width-1:0] mem [depth];
  logic [aw-1:0]    wp;
  logic [aw-1:0]    rp;
  logic [aw:0]      count;
  logic             push;
  logic             pop;

  assign wr.ready = (count != (aw+1)'(depth));
  assign rd.valid = (count != '0);
  assign rd.data  = mem[rp];
  assign push     = wr.valid && wr.ready;
  assign pop      = rd.valid && rd.ready;

  always_ff @(posedge mclk)
  begin
    if (push)
      mem[wp] <= wr.data;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      wp    <= '0;
      rp    <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wp <= wp + 1'b1;
      if (pop)
        rp <= rp + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end
endmodule

// [src/flash_seq_pkg.sv]
// Purpose: Shared constants and types for the parallel flash command sequencer
// Assumes: 25 MHz mclk, byte-wide flash behind an asynchronous parallel bus
// Notes:   All command offsets are relative to the selected chip base
package flash_seq_pkg;
  localparam logic [23:0] off_unlock1   = 24'h005555;
  localparam logic [23:0] off_unlock2   = 24'h002aaa;
  localparam logic [23:0] off_zero      = 24'h000000;
  localparam logic [23:0] off_id1       = 24'h000001;
  localparam logic [7:0]  dat_unlock1   = 8'haa;
  localparam logic [7:0]  dat_unlock2   = 8'h55;
  localparam logic [7:0]  cmd_program   = 8'ha0;
  localparam logic [7:0]  cmd_id_enter  = 8'h90;
  localparam logic [7:0]  cmd_id_leave  = 8'hf0;
  localparam logic [7:0]  cmd_erase1    = 8'h80;
  localparam logic [7:0]  cmd_erase2    = 8'h10;
  localparam logic [7:0]  dat_erased    = 8'hff;
  localparam int          clk_mhz       = 25;
  localparam int          settle_us     = 10;
  localparam int          settle_cycles = settle_us * clk_mhz;
  localparam int          strobe_cycles = 3;
  localparam logic [8:0]  page_one      = 9'h001;
  localparam logic [8:0]  page_128      = 9'h080;
  localparam logic [8:0]  page_256      = 9'h100;
  localparam logic [23:0] cmp_span      = 24'h000400;
  localparam logic [23:0] mirror_step   = 24'h020000;

  typedef enum logic [2:0] {
    op_program  = 3'h0,
    op_erase    = 3'h1,
    op_id_enter = 3'h2,
    op_id_leave = 3'h3,
    op_read_id  = 3'h4,
    op_compare  = 3'h5
  } op_t;
endpackage

// [src/flash_sequencer.sv]
// Purpose: Drive command sequences and completion waits into a parallel flash
// Assumes: Flash data inputs are synchronous to mclk; strobes held strobe_cycles
// Notes:   Runs from a requester port; one operation at a time
//
// What this block does
// - Page program sends AA/5555, 55/2AAA, A0/5555, then page bytes.
// - Identify entry sends unlock pair then 90/5555; id bytes at 0 and 1.
// - Identify exit sends unlock pair then F0/5555.
// - Chip erase sends two unlocked sequences ending 80 then 10.
// - Every command address is chip base plus command offset.
// - Page length per request: one, 128 or 256 bytes.
// - Host code must not run from the flash being programmed.
// - Completion wait follows erase and the last byte of a page.
// - Completion wait also follows identify entry and exit.
// - Wait step one is a fixed delay of at least 10 us.
// - Wait step two reads the poll address until two reads agree.
// - Wait step three reads until data matches; skipped for identify.
// - Poll address/data: last written, or 0000/FF for erase, 0000 for identify.
// - Board check compares 400h bytes at base against base plus 20000h.
// - Second chip check compares 400h bytes between bases per id combination.
// - All combinations equal means mirror; else identify at second base. This block only reports differ; the requester decides.
module flash_sequencer #(
  parameter int          depth     = 32,
  parameter int          id_count  = 4,
  parameter logic [15:0] id_table  [id_count] = '{16'h0102, 16'h0304, 16'h0506, 16'h0708},
  parameter logic [1:0]  id_pages  [id_count] = '{2'h0, 2'h1, 2'h2, 2'h1},
  parameter int          settle_ck = flash_seq_pkg::settle_cycles
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        req,
  input  wire logic [2:0]  req_op,
  input  wire logic [23:0] req_base,
  input  wire logic [23:0] req_addr,
  input  wire logic [23:0] req_other,
  input  wire logic [7:0]  wr_data,
  input  wire logic        wr_valid,
  output logic             wr_ready,
  output logic             busy,
  output logic             done,
  output logic             refused,
  output logic [15:0]      id_pair,
  output logic             id_known,
  output logic             differ,
  output logic [23:0]      flash_addr,
  output logic [7:0]       flash_dout,
  output logic             flash_doe,
  input  wire logic [7:0]  flash_din,
  output logic             flash_we_n,
  output logic             flash_oe_n
);
  typedef enum logic [3:0] {
    st_idle   = 4'b0000,
    st_cmd    = 4'b0001,
    st_data   = 4'b0011,
    st_settle = 4'b0010,
    st_toggle = 4'b0110,
    st_match  = 4'b0111,
    st_done   = 4'b0101,
    st_idrd   = 4'b0100,
    st_cmp    = 4'b1100
  } state_t;

  state_t      state;
  flash_seq_pkg::op_t op;
  logic [23:0] base;
  logic [23:0] other;
  logic [23:0] addr;
  logic [2:0]  step;
  logic [8:0]  page_len;
  logic [8:0]  sent;
  localparam int ow = $clog2(depth) + 1;
  logic [ow-1:0] occ;
  logic [ow-1:0] next_occ;
  logic [15:0] timer;
  logic [2:0]  phase;
  logic        access;
  logic        is_read;
  logic [7:0]  prev;
  logic        have_prev;
  logic [23:0] poll_addr;
  logic [7:0]  poll_data;
  logic [23:0] cmp_idx;
  logic [7:0]  cmp_first;
  logic        second;
  logic        idx_hit;
  logic [1:0]  idx_page;
  logic        last_phase;

  flash_stream_if #(.width(8)) fin ();
  flash_stream_if #(.width(8)) fout ();

  assign fin.data  = wr_data;
  assign fin.valid = wr_valid && wr_ready;
  assign fout.ready = (state == st_data) && !access;
  // Ready is a flop, so it may only promise room that still exists next cycle
  assign next_occ  = occ + ow'(fin.valid && fin.ready) - ow'(fout.valid && fout.ready);

  flash_fifo #(.width(8), .depth(depth)) u_fifo (
    .mclk  (mclk),
    .rst_n (rst_n),
    .wr    (fin),
    .rd    (fout)
  );

  // Lookup is a loop over the configurable table
  always_comb
  begin
    idx_hit  = 1'b0;
    idx_page = 2'h0;
    for (int i = 0; i < id_count; i++)
      if (id_table[i] == id_pair)
      begin
        idx_hit  = 1'b1;
        idx_page = id_pages[i];
      end
  end

  assign last_phase = (phase == 3'(flash_seq_pkg::strobe_cycles));

  // Command byte and offset per step; erase repeats the unlock pair
  function automatic logic [31:0] cmd_word(input flash_seq_pkg::op_t o, input logic [2:0] s);
    logic [7:0] last;
    last = flash_seq_pkg::cmd_program;
    unique case (o)
      flash_seq_pkg::op_id_enter: last = flash_seq_pkg::cmd_id_enter;
      flash_seq_pkg::op_id_leave: last = flash_seq_pkg::cmd_id_leave;
      flash_seq_pkg::op_erase:
        last = (s < 3'h3) ? flash_seq_pkg::cmd_erase1 : flash_seq_pkg::cmd_erase2;
      default: last = flash_seq_pkg::cmd_program;
    endcase
    unique case (s)
      3'h0, 3'h3: cmd_word = {flash_seq_pkg::off_unlock1, flash_seq_pkg::dat_unlock1};
      3'h1, 3'h4: cmd_word = {flash_seq_pkg::off_unlock2, flash_seq_pkg::dat_unlock2};
      default:    cmd_word = {flash_seq_pkg::off_unlock1, last};
    endcase
  endfunction

  // Bus strobe timing: address set, strobe low, release
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      phase      <= '0;
      flash_we_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_doe  <= 1'b0;
    end
    else if (access && !last_phase)
    begin
      phase      <= phase + 1'b1;
      flash_we_n <= is_read;
      flash_oe_n <= !is_read;
      flash_doe  <= !is_read;
    end
    else
    begin
      phase      <= '0;
      flash_we_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_doe  <= 1'b0;
    end
  end

  // Main sequencing
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state      <= st_idle;
      op         <= flash_seq_pkg::op_program;
      base       <= '0;
      other      <= '0;
      addr       <= '0;
      step       <= '0;
      page_len   <= flash_seq_pkg::page_one;
      sent       <= '0;
      timer      <= '0;
      access     <= 1'b0;
      is_read    <= 1'b0;
      prev       <= '0;
      have_prev  <= 1'b0;
      poll_addr  <= '0;
      poll_data  <= '0;
      cmp_idx    <= '0;
      cmp_first  <= '0;
      second     <= 1'b0;
      busy       <= 1'b0;
      done       <= 1'b0;
      refused    <= 1'b0;
      id_pair    <= '0;
      id_known   <= 1'b0;
      differ     <= 1'b0;
      flash_addr <= '0;
      flash_dout <= '0;
      wr_ready   <= 1'b0;
      occ        <= '0;
    end
    else
    begin
      done     <= 1'b0;
      refused  <= 1'b0;
      wr_ready <= (next_occ != ow'(depth));
      occ      <= next_occ;
      if (access && last_phase)
        access <= 1'b0;
      unique case (state)
        st_idle:
          if (req)
          begin
            op      <= flash_seq_pkg::op_t'(req_op);
            base    <= req_base;
            other   <= req_other;
            addr    <= req_addr;
            step    <= '0;
            sent    <= '0;
            unique case (idx_page)
              2'h0:    page_len <= flash_seq_pkg::page_one;
              2'h1:    page_len <= flash_seq_pkg::page_128;
              default: page_len <= flash_seq_pkg::page_256;
            endcase
            if (req_op == 3'(flash_seq_pkg::op_program) && !idx_hit)
              refused <= 1'b1;
            else
            begin
              busy  <= 1'b1;
              state <= (req_op == 3'(flash_seq_pkg::op_read_id)) ? st_idrd :
                       (req_op == 3'(flash_seq_pkg::op_compare)) ? st_cmp : st_cmd;
            end
          end
        st_cmd:
          if (!access)
          begin
            // Host code must not run from this flash until done
            {flash_addr, flash_dout} <= cmd_word(op, step) + {base, 8'h00};
            is_read <= 1'b0;
            access  <= 1'b1;
            step    <= step + 1'b1;
            if ((op == flash_seq_pkg::op_erase) ? (step == 3'h5) : (step == 3'h2))
              state <= (op == flash_seq_pkg::op_program) ? st_data : st_settle;
            timer <= '0;
            poll_addr <= base + flash_seq_pkg::off_zero;
            poll_data <= flash_seq_pkg::dat_erased;
          end
        st_data:
          if (!access && fout.valid)
          begin
            flash_addr <= base + addr + 24'(sent);
            flash_dout <= fout.data;
            poll_addr  <= base + addr + 24'(sent);
            poll_data  <= fout.data;
            is_read    <= 1'b0;
            access     <= 1'b1;
            sent       <= sent + 1'b1;
            if (sent + 1'b1 == page_len)
            begin
              timer <= '0;
              state <= st_settle;
            end
          end
        st_settle:
          if (!access)
          begin
            // Delay is long enough for the slowest parts; costs ~10 us per op
            if (timer == 16'(settle_ck - 1))
            begin
              have_prev <= 1'b0;
              state     <= st_toggle;
            end
            else
              timer <= timer + 1'b1;
          end
        st_toggle:
          if (access && last_phase)
          begin
            prev      <= flash_din;
            have_prev <= 1'b1;
            // Bit 6 flipping between reads means still busy
            if (have_prev && prev == flash_din)
              state <= (op == flash_seq_pkg::op_id_enter || op == flash_seq_pkg::op_id_leave)
                       ? st_done : st_match;
          end
          else if (!access)
          begin
            flash_addr <= poll_addr;
            is_read    <= 1'b1;
            access     <= 1'b1;
          end
        st_match:
          if (access && last_phase)
          begin
            if (flash_din == poll_data)
              state <= st_done;
          end
          else if (!access)
          begin
            flash_addr <= poll_addr;
            is_read    <= 1'b1;
            access     <= 1'b1;
          end
        st_idrd:
          // Reads return id bytes only in identify mode
          if (access && last_phase)
          begin
            if (!second)
              id_pair[15:8] <= flash_din;
            else
            begin
              id_pair[7:0] <= flash_din;
              state        <= st_done;
            end
            second <= !second;
          end
          else if (!access)
          begin
            flash_addr <= base + (second ? flash_seq_pkg::off_id1 : flash_seq_pkg::off_zero);
            is_read    <= 1'b1;
            access     <= 1'b1;
          end
        st_cmp:
          // Requester picks other = base+20000h or second base
          if (access && last_phase)
          begin
            if (!second)
              cmp_first <= flash_din;
            else
            begin
              if (cmp_first != flash_din)
                differ <= 1'b1;
              cmp_idx <= cmp_idx + 1'b1;
              if (cmp_idx + 1'b1 == flash_seq_pkg::cmp_span)
                state <= st_done;
            end
            second <= !second;
          end
          else if (!access)
          begin
            if (cmp_idx == '0 && !second)
              differ <= 1'b0;
            flash_addr <= (second ? other : base) + cmp_idx;
            is_read    <= 1'b1;
            access     <= 1'b1;
          end
        st_done:
        begin
          id_known <= idx_hit;
          cmp_idx  <= '0;
          second   <= 1'b0;
          busy     <= 1'b0;
          done     <= 1'b1;
          state    <= st_idle;
        end
        default:
          state <= st_idle;
      endcase
    end
  end
endmodule

// [src/flash_stream_if.sv]
// Purpose: Byte stream carrier between the sequencer and its data FIFO
// Assumes: Single clock domain
// Notes:   Valid/ready handshake, a word moves when both are high
interface flash_stream_if #(parameter int width = 8);
  logic [width-1:0] data;
  logic             valid;
  logic             ready;
  modport source (output data, output valid, input ready);
  modport sink   (input data, input valid, output ready);
endinterface
